// *** design/srch_map.svh ***
// register offsets, bit positions, reset values and timing counts
`ifndef SRCH_MAP_SVH
`define SRCH_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SRCH_OFS_FRAME0 8'h00
`define SRCH_OFS_FRAME1 8'h04
`define SRCH_OFS_RESP0 8'h08
`define SRCH_OFS_RESP1 8'h0c
`define SRCH_OFS_STATUS 8'h10
`define SRCH_OFS_ALARM 8'h14
`define SRCH_OFS_INTST 8'h18
`define SRCH_OFS_INTMASK 8'h1c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRCH_ST_COMMAND_ACCEPT_FLAG 0
`define SRCH_ST_READY 1
`define SRCH_ST_ALARM 2
`define SRCH_ST_HOLDOFF 3
`define SRCH_EV_DONE 0
`define SRCH_EV_COND 1
`define SRCH_EV_BAD 2
// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define SRCH_CODE_SETUP 8'h04
`define SRCH_MODE_KEEP 8'h00
`define SRCH_MODE_TIMED 8'h01
`define SRCH_MODE_OFF 8'h02
`define SRCH_RST_WORD 32'h0000_0000
`define SRCH_RST_EV 3'h0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRCH_CLK_KHZ 50000
`define SRCH_MODE1_LIMIT_MS 5000
`define SRCH_EXEC_CYCLES 16
`endif

// *** design/srch_pkg.sv ***
// types shared by the setup request handler
package srch_pkg;
  // execution state of the setup request
  typedef enum logic {ST_IDLE, ST_EXEC} srch_state_t;
endpackage : srch_pkg

// *** design/srch_timer_if.sv ***
// link between the handler core and its execution timer
`timescale 1ns/1ns
`default_nettype none
interface srch_timer_if;
  logic start; // one-cycle launch of an execution
  logic limitOn; // completion bound applies (mode 1)
  logic done; // one-cycle end of execution
  logic [31:0] count; // cycles spent so far
  modport ctrl (output start, output limitOn, input done, input count);
  modport timer (input start, input limitOn, output done, output count);
endinterface : srch_timer_if
`default_nettype wire

// *** design/srch_exec_timer.sv ***
// execution timer: runs the apply time, cut short by the mode 1 bound
`timescale 1ns/1ns
`default_nettype none
module srch_exec_timer #(
  parameter logic [31:0] EXEC_CYCLES = 32'd16, // apply duration
  parameter logic [31:0] LIMIT_CYCLES = 32'd250000000 // mode 1 bound
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable, freezes all
  srch_timer_if.timer tif // launch and completion
);
  logic running; // an execution is timing
  logic limitSeen; // bound latched at launch
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // the bound forces completion so a slow apply can never overrun
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      running <= 1'b0;
      limitSeen <= 1'b0;
      tif.count <= 32'h0000_0000;
      tif.done <= 1'b0;
    end
    else if (ce)
    begin
      tif.done <= 1'b0;
      if (tif.start)
      begin
        running <= 1'b1;
        limitSeen <= tif.limitOn;
        tif.count <= 32'h0000_0000;
      end
      else if (running)
      begin
        tif.count <= tif.count + 32'h0000_0001;
        if (tif.count == EXEC_CYCLES - 32'h0000_0001 ||
            (limitSeen && tif.count == LIMIT_CYCLES - 32'h0000_0002))
        begin
          running <= 1'b0;
          tif.done <= 1'b1;
        end
      end
    end
  end
endmodule : srch_exec_timer
`default_nettype wire

// *** design/srch_top.sv ***
// setup request command handler with APB register access
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "srch_map.svh"
module srch_top #(
  parameter logic [31:0] LIMIT_CYCLES =
    `SRCH_MODE1_LIMIT_MS * `SRCH_CLK_KHZ // mode 1 bound in cycles
) (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable, freezes all
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic servoEnergized, // servo is powered on
  input wire logic readyCond, // servo would be ready
  input wire logic alarmIn, // alarm present
  input wire logic [7:0] alarmCodeIn, // active alarm code
  output logic servoReady, // servo ready output
  output logic paramApply, // pulse: stored params take effect
  output logic irq // level interrupt
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  srch_timer_if tif (); // core to timer link
  srch_pkg::srch_state_t state; // execution state
  logic [31:0] frame0; // command bytes 0..3
  logic [31:0] frame1; // command bytes 4..7
  logic [31:0] resp0; // response bytes 0..3
  logic [31:0] resp1; // response bytes 4..7
  logic [7:0] modeReg; // mode of the running request
  logic holdOff; // ready held off after mode 2
  logic alarmFlag; // alarm status
  logic [7:0] alarmCode; // alarm code as reported
  logic [2:0] intStat; // sticky events
  logic [2:0] intMask; // event enables
  logic [2:0] evt; // events this cycle
  logic [31:0] rdMux; // read data selection
  logic mapped; // address hits a register
  logic apbWr; // write takes effect now
  logic launch; // frame 0 written while idle
  logic goodFrame; // code and mode are valid
  logic acceptExec; // request starts executing
  logic [31:0] execCnt; // cycles in execution, checks only

  // decode of one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign apbWr = psel && penable && pready && pwrite;
  assign launch = apbWr && hit(paddr, `SRCH_OFS_FRAME0) &&
    state == srch_pkg::ST_IDLE;
  // unknown code or mode is refused like any malformed frame
  assign goodFrame = pwdata[7:0] == `SRCH_CODE_SETUP &&
    frame1[7:0] <= `SRCH_MODE_OFF;
  assign acceptExec = launch && goodFrame && !servoEnergized;
  assign tif.start = acceptExec && ce;
  assign tif.limitOn = frame1[7:0] == `SRCH_MODE_TIMED;

  srch_exec_timer #(
    .EXEC_CYCLES(`SRCH_EXEC_CYCLES),
    .LIMIT_CYCLES(LIMIT_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .tif(tif)
  );

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // read mux; reserved bits read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      `SRCH_OFS_FRAME0: rdMux = frame0;
      `SRCH_OFS_FRAME1: rdMux = frame1;
      `SRCH_OFS_RESP0: rdMux = resp0;
      `SRCH_OFS_RESP1: rdMux = resp1;
      `SRCH_OFS_STATUS:
      begin
        rdMux[`SRCH_ST_COMMAND_ACCEPT_FLAG] = state == srch_pkg::ST_IDLE;
        rdMux[`SRCH_ST_READY] = servoReady;
        rdMux[`SRCH_ST_ALARM] = alarmFlag;
        rdMux[`SRCH_ST_HOLDOFF] = holdOff;
      end
      `SRCH_OFS_ALARM: rdMux[7:0] = alarmCode;
      `SRCH_OFS_INTST: rdMux[2:0] = intStat;
      `SRCH_OFS_INTMASK: rdMux[2:0] = intMask;
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free access: answer is latched during the setup cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= `SRCH_RST_WORD;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && !penable && !pready;
      if (psel && !penable)
      begin
        prdata <= pwrite ? `SRCH_RST_WORD : rdMux;
        pslverr <= !mapped;
      end
    end
  end

  // command frame words; frame 0 is locked while a request runs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame0 <= `SRCH_RST_WORD;
      frame1 <= `SRCH_RST_WORD;
    end
    else if (ce)
    begin
      if (launch)
        frame0 <= pwdata;
      if (apbWr && hit(paddr, `SRCH_OFS_FRAME1))
        frame1 <= pwdata;
    end
  end

  // response echoes the frame, code byte included
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp0 <= `SRCH_RST_WORD;
      resp1 <= `SRCH_RST_WORD;
    end
    else if (ce && launch)
    begin
      resp0 <= pwdata;
      resp1 <= frame1;
    end
  end

  // ----------------------------------------------------------------
  // execution sequence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= srch_pkg::ST_IDLE;
      modeReg <= `SRCH_MODE_KEEP;
    end
    else if (ce)
    begin
      unique case (state)
        srch_pkg::ST_IDLE:
          if (acceptExec)
          begin
            state <= srch_pkg::ST_EXEC;
            modeReg <= frame1[7:0];
          end
        srch_pkg::ST_EXEC:
          if (tif.done)
            state <= srch_pkg::ST_IDLE;
      endcase
    end
  end

  // parameters go live as the apply finishes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      paramApply <= 1'b0;
    else if (ce)
      paramApply <= tif.done;
  end

  // mode 2 keeps ready off until the next accepted request finishes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      holdOff <= 1'b0;
    else if (ce && tif.done)
      holdOff <= modeReg == `SRCH_MODE_OFF;
  end

  // ready follows the servo except while running or held off
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      servoReady <= 1'b0;
    else if (ce)
      servoReady <= readyCond && state == srch_pkg::ST_IDLE &&
        !acceptExec && !holdOff;
  end

  // alarm is tracked the same way whether or not a request runs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarmFlag <= 1'b0;
      alarmCode <= 8'h00;
    end
    else if (ce)
    begin
      alarmFlag <= alarmIn;
      alarmCode <= alarmCodeIn;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    evt = `SRCH_RST_EV;
    evt[`SRCH_EV_DONE] = tif.done;
    evt[`SRCH_EV_COND] = launch && goodFrame && servoEnergized;
    evt[`SRCH_EV_BAD] = launch && !goodFrame;
  end

  // write one clears; an event in the same cycle wins
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      intStat <= `SRCH_RST_EV;
      intMask <= `SRCH_RST_EV;
    end
    else if (ce)
    begin
      if (apbWr && hit(paddr, `SRCH_OFS_INTST))
        intStat <= (intStat & ~pwdata[2:0]) | evt;
      else
        intStat <= intStat | evt;
      if (apbWr && hit(paddr, `SRCH_OFS_INTMASK))
        intMask <= pwdata[2:0];
    end
  end

  // registered, so irq trails the status bit by one cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else if (ce)
      irq <= |(intStat & intMask);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // elapsed execution time seen from the core side
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      execCnt <= 32'h0000_0000;
    else if (ce)
      execCnt <= (state == srch_pkg::ST_EXEC) ?
        execCnt + 32'h0000_0001 : 32'h0000_0000;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !ce);

  sequence seqAccept;
    acceptExec ##1 (state == srch_pkg::ST_EXEC && !servoReady);
  endsequence
  sequence seqFinish;
    tif.done ##1 (state == srch_pkg::ST_IDLE && paramApply);
  endsequence

  AST_ECHO_CODE: assert property (
    launch |=> resp0[7:0] == $past(pwdata[7:0]))
    else $error("response code is not the echoed code");
  AST_MODE1_BOUND: assert property (
    (state == srch_pkg::ST_EXEC && modeReg == `SRCH_MODE_TIMED)
      |-> execCnt < LIMIT_CYCLES)
    else $error("mode 1 execution ran past its bound");
  AST_APPLY: assert property (tif.done |-> seqFinish)
    else $error("parameters not applied at completion");
  AST_READY_OFF: assert property (acceptExec |-> seqAccept)
    else $error("ready not off while executing");
  AST_MODE2_OFF: assert property (
    (tif.done && modeReg == `SRCH_MODE_OFF) |=> ##1 !servoReady [*2])
    else $error("ready returned after a mode 2 request");
  // done is a one-cycle pulse, so the condition is looked at once after it
  AST_MODE0_KEEP: assert property (
    (tif.done && modeReg == `SRCH_MODE_KEEP) ##1 (readyCond && !acceptExec)
      |=> servoReady)
    else $error("ready not restored after a mode 0 request");
  // checks the word the bus really returns, not the mux that builds it
  AST_COMMAND_ACCEPT_FLAG: assert property (
    (psel && !penable && !pwrite && paddr == `SRCH_OFS_STATUS &&
      state == srch_pkg::ST_EXEC) |=> !prdata[`SRCH_ST_COMMAND_ACCEPT_FLAG])
    else $error("command-ready reads 1 while executing");
  // sampled reset and enable gate the start, so a release is not misread
  AST_ALARM_KEPT: assert property (
    (rst_b && ce) |=>
      (alarmFlag == $past(alarmIn) && alarmCode == $past(alarmCodeIn)))
    else $error("alarm status not carried through");
  AST_ENERGIZED: assert property (
    (launch && servoEnergized) |=>
      state == srch_pkg::ST_IDLE && intStat[`SRCH_EV_COND])
    else $error("request while energized was not refused");
endmodule : srch_top
`default_nettype wire

// *** testbench/srch_host_model.sv ***
// host model: apb master standing in for the motion controller
`timescale 1ns/1ns
`default_nettype none
`include "srch_map.svh"
module srch_host_model (
  input wire logic sys_clk, // system clock
  output var logic psel, // apb select
  output var logic penable, // apb access phase
  output var logic pwrite, // apb direction
  output var logic [7:0] paddr, // apb byte address
  output var logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  // ----------------------------------------------------------------
  // bus idle from time zero
  // ----------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no latency assumed: wait for the answer; the bench watchdog bounds it
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // mode goes in first, the code write launches the request
  task automatic setupRequest(input logic [7:0] code,
                              input logic [7:0] mode);
    logic [31:0] r;
    logic e;
    xfer(1'b1, `SRCH_OFS_FRAME1, {24'h00_0000, mode}, r, e);
    xfer(1'b1, `SRCH_OFS_FRAME0, {24'h00_0000, code}, r, e);
  endtask : setupRequest
endmodule : srch_host_model
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the setup request handler
`timescale 1ns/1ns
`default_nettype none
`include "srch_map.svh"
module testbench;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] code; logic [7:0] mode; logic energ;
    logic [2:0] ev; logic rdy;} srch_row_t;
  logic sys_clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, alarmCodeIn;
  logic [31:0] pwdata, prdata, rd;
  logic servoEnergized, readyCond, alarmIn, servoReady, paramApply, irq;
  logic er;
  int nErrors, compares, cyc, applyCount, applyCyc, launchCyc, n;
  srch_row_t rows [7];
  `define CHK(nm, ex, gt) \
    begin compares++; if ((gt) !== (ex)) begin nErrors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
  srch_top #(.LIMIT_CYCLES(32'd64)) i_dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servoEnergized(servoEnergized),
    .readyCond(readyCond), .alarmIn(alarmIn), .alarmCodeIn(alarmCodeIn),
    .servoReady(servoReady), .paramApply(paramApply), .irq(irq));
  srch_host_model i_host (.sys_clk(sys_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------------------------------
  // clock, cycle count and apply pulse monitor
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (paramApply === 1'b1)
    begin
      applyCount++;
      applyCyc = cyc;
    end
  end
  // closing verdict, shared with the watchdog
  task automatic tallyAndFinish;
    if (nErrors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tallyAndFinish
  // watchdog: whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    tallyAndFinish();
  end
  // poll command-ready until set, bounded
  task automatic waitIdle;
    n = 0;
    do
    begin
      i_host.xfer(1'b0, `SRCH_OFS_STATUS, 32'h0, rd, er);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 40);
  endtask : waitIdle
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{'{8'h04, 8'h00, 0, 3'h1, 1}, '{8'h04, 8'h01, 0, 3'h1, 1},
      '{8'h04, 8'h02, 0, 3'h1, 0}, '{8'h04, 8'h00, 1, 3'h2, 0},
      '{8'h05, 8'h00, 0, 3'h4, 0}, '{8'h04, 8'h03, 0, 3'h4, 0},
      '{8'h04, 8'h00, 0, 3'h1, 1}};
    {rst_b, ce, servoEnergized, readyCond, alarmIn} = 5'b01010;
    alarmCodeIn = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    alarmIn <= 1'b1;
    alarmCodeIn <= 8'h5a;
    i_host.xfer(1'b1, `SRCH_OFS_INTMASK, 32'h7, rd, er);
    for (int i = 0; i < 7; i++)
    begin
      servoEnergized <= rows[i].energ;
      applyCount = 0;
      i_host.setupRequest(rows[i].code, rows[i].mode);
      launchCyc = cyc;
      i_host.xfer(1'b0, `SRCH_OFS_RESP0, 32'h0, rd, er);
      `CHK("echo", {24'h0, rows[i].code}, rd)
      // accepted: status sampled while executing
      if (rows[i].ev == 3'h1)
      begin
        i_host.xfer(1'b0, `SRCH_OFS_STATUS, 32'h0, rd, er);
        `CHK("exec status", 3'b100, rd[2:0])
        i_host.xfer(1'b0, `SRCH_OFS_ALARM, 32'h0, rd, er);
        `CHK("alarm code", 8'h5a, rd[7:0])
      end
      waitIdle();
      `CHK("cmd ready", 1'b1, rd[0])
      repeat (3) @(posedge sys_clk);
      `CHK("ready out", rows[i].rdy, servoReady)
      `CHK("applied", (rows[i].ev == 3'h1), applyCount == 1)
      if (rows[i].ev == 3'h1)
        `CHK("bound", 1'b1, applyCyc - launchCyc <= 64)
      i_host.xfer(1'b0, `SRCH_OFS_INTST, 32'h0, rd, er);
      `CHK("events", rows[i].ev, rd[2:0])
      `CHK("irq set", 1'b1, irq)
      i_host.xfer(1'b1, `SRCH_OFS_INTST, 32'h7, rd, er);
      repeat (2) @(posedge sys_clk);
      `CHK("irq clear", 1'b0, irq)
    end
    // clock enable low freezes ready although its condition drops
    ce <= 1'b0;
    readyCond <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("frozen ready", 1'b1, servoReady)
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("ready follows", 1'b0, servoReady)
    readyCond <= 1'b1;
    // unmapped address answers with an error and zero data
    i_host.xfer(1'b0, 8'h20, 32'h0, rd, er);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    // second launch while executing is dropped without event
    i_host.setupRequest(8'h04, 8'h00);
    i_host.xfer(1'b1, `SRCH_OFS_FRAME0, 32'h5, rd, er);
    i_host.xfer(1'b0, `SRCH_OFS_RESP0, 32'h0, rd, er);
    `CHK("echo kept", 32'h4, rd)
    waitIdle();
    i_host.xfer(1'b0, `SRCH_OFS_INTST, 32'h0, rd, er);
    `CHK("only done", 3'h1, rd[2:0])
    // masked event keeps irq low
    i_host.xfer(1'b1, `SRCH_OFS_INTMASK, 32'h0, rd, er);
    i_host.setupRequest(8'h07, 8'h00);
    repeat (3) @(posedge sys_clk);
    `CHK("masked irq", 1'b0, irq)
    // reset in mid-run returns the handler to idle
    i_host.setupRequest(8'h04, 8'h02);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHK("reset ready", 1'b0, servoReady)
    rst_b <= 1'b1;
    i_host.xfer(1'b0, `SRCH_OFS_STATUS, 32'h0, rd, er);
    `CHK("reset idle", 1'b1, rd[0])
    i_host.xfer(1'b0, `SRCH_OFS_INTST, 32'h0, rd, er);
    `CHK("reset events", 32'h0, rd)
    i_host.xfer(1'b0, `SRCH_OFS_INTMASK, 32'h0, rd, er);
    `CHK("reset mask", 32'h0, rd)
    tallyAndFinish();
  end
endmodule : testbench
`default_nettype wire
